// [logic/ipf_pkg.sv]
// package: register map, field layout and reset values of the priority fields
package ipf_pkg;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned LEVEL_W     = 3;
  localparam int unsigned NUM_SRC     = 4;
  // register offsets (word index on the plain register port)
  localparam logic [3:0]  EXT_INT1_PRIORITY_OFS       = 4'h0;
  localparam logic [3:0]  TIMER4_COMPARE_PRIORITY_OFS = 4'h1;
  // field positions (low bit of each 3-bit field)
  localparam int unsigned EXT_SOURCE1_LSB = 0;
  localparam int unsigned COMPARE_CH3_LSB = 4;
  localparam int unsigned COMPARE_CH4_LSB = 8;
  localparam int unsigned TIMER_FOUR_LSB  = 12;
  // power-on level of every field, and the code that takes a source out of arbitration
  localparam logic [2:0]  LEVEL_RESET     = 3'h4;
  localparam logic [2:0]  LEVEL_DISABLED  = 3'h0;
  // source index into the level vector
  localparam int unsigned SRC_EXT1 = 0;
  localparam int unsigned SRC_TMR4 = 1;
  localparam int unsigned SRC_OC4  = 2;
  localparam int unsigned SRC_OC3  = 3;
endpackage

// [logic/ipf_level_if.sv]
// interface: per-source priority level and its enable
`timescale 1ns/1ps
interface ipf_level_if #(parameter int unsigned N = 4);
  logic [N-1:0][2:0] level;
  logic [N-1:0]      enabled;
  modport src (output level, output enabled);
  modport dst (input level, input enabled);
endinterface

// [logic/ipf_level_decode.sv]
// decode of each stored field into an arbitration enable
`timescale 1ns/1ps
module ipf_level_decode
  import ipf_pkg::*;
#(
  parameter int unsigned N = 4
) (
  // stored fields
  input  wire logic [N-1:0][2:0] field_in,
  // decoded view
  ipf_level_if.src               lv
);
  generate
    // an empty level vector leaves nothing to arbitrate
    if (N < 1) begin : g_bad_n
      $error("ipf_level_decode: N must be at least one");
    end
    for (genvar i = 0; i < N; i++) begin : g_src
      // code is the level itself, 1..7
      assign lv.level[i]   = field_in[i];
      // zero takes the source out of arbitration
      assign lv.enabled[i] = (field_in[i] != LEVEL_DISABLED);
    end
  endgenerate
endmodule // ipf_level_decode

// [logic/ipf_priority_regs.sv]
// top: two priority registers with decoded levels to the arbiter
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module ipf_priority_regs
  import ipf_pkg::*;
(
  // clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rstn_in,
  // register port
  input  wire logic [ipf_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [ipf_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                      wr_in,
  input  wire logic                      rd_in,
  output logic      [ipf_pkg::DATA_W-1:0] rdata_out,
  // levels toward arbitration
  output logic      [2:0]                ext_source1_level_out,
  output logic      [2:0]                timer_four_level_out,
  output logic      [2:0]                compare_ch4_level_out,
  output logic      [2:0]                compare_ch3_level_out,
  output logic      [3:0]                src_enable_out
);
  import ipf_pkg::*;

  logic [2:0] ext_source1_level;
  logic [2:0] timer_four_level;
  logic [2:0] compare_ch4_level;
  logic [2:0] compare_ch3_level;
  logic [NUM_SRC-1:0][2:0] fields;
  logic [15:0] next_rdata;

  ipf_level_if #(.N(NUM_SRC)) lv ();

  ////////////////////////////////////////////////////////////////////////
  // field storage
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_source1_level <= LEVEL_RESET;
      timer_four_level  <= LEVEL_RESET;
      compare_ch4_level <= LEVEL_RESET;
      compare_ch3_level <= LEVEL_RESET;
    end else if (wr_in) begin
      if (addr_in == EXT_INT1_PRIORITY_OFS) begin
        // upper bits dropped
        ext_source1_level <= wdata_in[EXT_SOURCE1_LSB +: 3];
      end
      if (addr_in == TIMER4_COMPARE_PRIORITY_OFS) begin
        timer_four_level  <= wdata_in[TIMER_FOUR_LSB +: 3];
        compare_ch4_level <= wdata_in[COMPARE_CH4_LSB +: 3];
        compare_ch3_level <= wdata_in[COMPARE_CH3_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets and unused bits read zero
  always_comb begin
    next_rdata = 16'h0000;
    if (addr_in == EXT_INT1_PRIORITY_OFS) begin
      next_rdata[EXT_SOURCE1_LSB +: 3] = ext_source1_level;
    end else if (addr_in == TIMER4_COMPARE_PRIORITY_OFS) begin
      next_rdata[TIMER_FOUR_LSB +: 3]  = timer_four_level;
      next_rdata[COMPARE_CH4_LSB +: 3] = compare_ch4_level;
      next_rdata[COMPARE_CH3_LSB +: 3] = compare_ch3_level;
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode toward arbitration
  assign fields[SRC_EXT1] = ext_source1_level;
  assign fields[SRC_TMR4] = timer_four_level;
  assign fields[SRC_OC4]  = compare_ch4_level;
  assign fields[SRC_OC3]  = compare_ch3_level;

  ipf_level_decode #(.N(NUM_SRC)) u_decode (
    .field_in (fields),
    .lv       (lv.src)
  );

  // registered so outputs come from flops; one cycle behind the field
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_source1_level_out <= LEVEL_RESET;
      timer_four_level_out  <= LEVEL_RESET;
      compare_ch4_level_out <= LEVEL_RESET;
      compare_ch3_level_out <= LEVEL_RESET;
      src_enable_out        <= 4'hf;
    end else begin
      ext_source1_level_out <= lv.level[SRC_EXT1];
      timer_four_level_out  <= lv.level[SRC_TMR4];
      compare_ch4_level_out <= lv.level[SRC_OC4];
      compare_ch3_level_out <= lv.level[SRC_OC3];
      src_enable_out        <= lv.enabled;
    end
  end
endmodule // ipf_priority_regs

// [bench/ipf_priority_regs_assertions.sv]
// checker: port-level behaviour of the two priority registers
`timescale 1ns/1ps
module ipf_chk (
  input wire logic        clk_in, rstn_in, wr_in, rd_in,
  input wire logic [3:0]  addr_in, src_enable_out,
  input wire logic [15:0] wdata_in, rdata_out,
  input wire logic [2:0]  ext_source1_level_out, timer_four_level_out,
  input wire logic [2:0]  compare_ch4_level_out, compare_ch3_level_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_ext_level_write: assert property (wr_in && addr_in == 4'h0 |-> ##2
    ext_source1_level_out == $past(wdata_in[2:0], 2)) else $error("ext level not written");
  a_ext_read_zero: assert property (rd_in && addr_in == 4'h0 |=>
    rdata_out == {13'h0, ext_source1_level_out}) else $error("ext register read wrong");
  a_timer_level_code: assert property (wr_in && addr_in == 4'h1 |-> ##2
    timer_four_level_out == $past(wdata_in[14:12], 2)) else $error("timer level wrong");
  a_ch3_level_code: assert property (wr_in && addr_in == 4'h1 |-> ##2
    compare_ch3_level_out == $past(wdata_in[6:4], 2)) else $error("ch3 level wrong");
  a_zero_disables: assert property (src_enable_out == {compare_ch3_level_out != 3'h0,
    compare_ch4_level_out != 3'h0, timer_four_level_out != 3'h0,
    ext_source1_level_out != 3'h0}) else $error("enable disagrees with level");
  a_second_reg_read: assert property (rd_in && addr_in == 4'h1 |=> rdata_out == {1'b0,
    timer_four_level_out, 1'b0, compare_ch4_level_out, 1'b0, compare_ch3_level_out, 4'h0})
    else $error("second register read wrong");
  a_reset_levels: assert property ($rose(rstn_in) |-> {ext_source1_level_out,
    timer_four_level_out, compare_ch4_level_out, compare_ch3_level_out} == 12'h924
    && src_enable_out == 4'hf) else $error("levels not at reset value");
  a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 16'h0000)
    else $error("read data not zero outside answer cycle");
  c_second_write: cover property (wr_in && addr_in == 4'h1);
  c_ext_read: cover property (rd_in && addr_in == 4'h0);
  c_source_off: cover property (src_enable_out != 4'hf);
endmodule // ipf_chk
bind ipf_priority_regs ipf_chk u_chk (.*);

// [bench/ipf_core_model.sv]
// partner model: core picks the highest level among enabled sources
`timescale 1ns/1ps
module ipf_core_model (
  input  wire logic [3:0][2:0] level_in,
  input  wire logic [3:0]      enable_in,
  output logic      [2:0]      top_level_out
);
  // a disabled source never wins, whatever code it still holds
  always_comb begin
    top_level_out = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (enable_in[i] && level_in[i] > top_level_out) top_level_out = level_in[i];
    end
  end
endmodule // ipf_core_model

// [bench/ipf_priority_regs_tb.sv]
// testbench: register accesses and decoded levels of the priority block
`timescale 1ns/1ps
module ipf_priority_regs_tb;
  logic        clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [3:0]  addr_in = 4'h0, src_enable_out;
  logic [15:0] wdata_in = 16'h0, rdata_out;
  logic [2:0]  ext_source1_level_out, timer_four_level_out, compare_ch4_level_out;
  logic [2:0]  compare_ch3_level_out, top_level;
  int          errors = 0, total_checks = 0;
  ipf_priority_regs DUT (.*);
  ipf_core_model u_core (.level_in({compare_ch3_level_out, compare_ch4_level_out,
    timer_four_level_out, ext_source1_level_out}), .enable_in(src_enable_out),
    .top_level_out(top_level));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // write ends once the level outputs have caught up
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk("rdata", e, rdata_out);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(4'h0, 16'h0004);
    rd(4'h1, 16'h4440);
    chk("enable", 16'hf, {12'h0, src_enable_out});
    for (int c = 1; c < 8; c++) begin
      wr(4'h0, {13'h1fff, c[2:0]});
      chk("ext level", {13'h0, c[2:0]}, {13'h0, ext_source1_level_out});
      rd(4'h0, {13'h0, c[2:0]});
    end
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h7770);
    wr(4'h5, 16'h0000);
    rd(4'h5, 16'h0000);
    wr(4'h1, 16'h7010);
    rd(4'h1, 16'h7010);
    chk("enable", 16'hb, {12'h0, src_enable_out});
    wr(4'h0, 16'hfff8);
    wr(4'h1, 16'h0000);
    chk("enable", 16'h0, {12'h0, src_enable_out});
    chk("core level", 16'h0, {13'h0, top_level});
    // mid-run reset must bring every field back to level 4
    @(posedge clk_in);
    rstn_in <= 1'b0;
    @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(4'h1, 16'h4440);
    chk("enable", 16'hf, {12'h0, src_enable_out});
    complete_run();
  end
  // whole sequence needs well under 200 cycles
  initial begin
    #5000;
    errors++;
    complete_run();
  end
endmodule // ipf_priority_regs_tb
